// File: hw/snt_rx.sv
// nibble pulse receiver with short and enhanced serial channel decode, apb registers
`timescale 1ns/1ps
`default_nettype none
module snt_rx
    import snt_pkg::*;
#(
    parameter int PW = 20,
    parameter int CAL_MIN = snt_pkg::CAL_MIN_CYC,
    parameter int CAL_MAX = snt_pkg::CAL_MAX_CYC
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // sensor line
    input wire logic sent_in
);
    import snt_pkg::*;
    localparam int AW = PW + 7;

    logic fall;
    logic [PW-1:0] period;

    snt_edge #(.PW(PW)) u_edge (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .line_in(sent_in),
        .fall(fall),
        .period(period)
    );

    // ---------------- register group ----------------
    logic [6:0] ctrl, next_ctrl;
    logic [3:0] flags, next_flags, flag_set;
    logic [31:0] rdata, next_rdata;
    logic err_q, next_err;
    logic wr_acc, mapped, en;
    logic [2:0] nn;

    always_comb begin
        mapped = (paddr == REG_CTRL) || (paddr == REG_STAT) || (paddr == REG_FRAME) ||
                 (paddr == REG_DATA) || (paddr == REG_SHORT) || (paddr == REG_ENH) ||
                 (paddr == REG_CAL);
        wr_acc = psel & penable & pwrite & mapped;
        en = ctrl[CTRL_EN_BIT];
        nn = ctrl[CTRL_NN_LSB +: 3];
        if (nn == 3'h0) begin
            nn = 3'h1;
        end else if (nn > 3'(MAX_NIB)) begin
            nn = 3'(MAX_NIB);
        end
    end

    logic [PW-1:0] cal;
    logic fs_sync;
    logic [3:0] fr_stat;
    logic [23:0] fr_data;
    logic fr_ok;
    logic [11:0] short_out;
    logic [24:0] enh_out;

    always_comb begin
        next_ctrl = ctrl;
        next_flags = flags;
        next_rdata = rdata;
        next_err = err_q;
        if (wr_acc && paddr == REG_CTRL) begin
            next_ctrl = pwdata[6:0];
        end
        if (wr_acc && paddr == REG_STAT) begin
            next_flags = flags & ~pwdata[3:0];
        end
        next_flags = next_flags | flag_set;
        if (psel && !penable) begin
            next_err = !mapped;
            next_rdata = '0;
            case (paddr)
                REG_CTRL: next_rdata = {25'h0, ctrl};
                REG_STAT: next_rdata = {23'h0, fs_sync, 4'h0, flags};
                REG_FRAME: next_rdata = {fr_ok, 27'h0, fr_stat};
                REG_DATA: next_rdata = {8'h00, fr_data};
                REG_SHORT: next_rdata = {20'h0, short_out};
                REG_ENH: next_rdata = {7'h00, enh_out};
                REG_CAL: next_rdata = 32'(cal);
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl <= CTRL_RESET;
            flags <= '0;
            rdata <= '0;
            err_q <= 1'b0;
        end else if (ce) begin
            ctrl <= next_ctrl;
            flags <= next_flags;
            rdata <= next_rdata;
            err_q <= next_err;
        end
    end

    assign pready = ce;
    assign prdata = rdata;
    assign pslverr = psel & penable & err_q;

    // ---------------- frame group ----------------
    snt_fs_e fs, next_fs;
    logic [PW-1:0] next_cal, dif;
    logic [AW-1:0] p112, next_p112, acc, next_acc, twocal;
    logic [4:0] n, next_n;
    logic [2:0] idx, next_idx;
    logic [3:0] crc, next_crc, val, next_fr_stat, stat_q, next_stat_q;
    logic [23:0] nib_sh, next_nib_sh, next_fr_data;
    logic nerr, next_nerr, cal_bad, next_cal_bad, paused, next_paused;
    logic done, next_done, next_fr_ok, bad, step;

    always_comb begin
        next_fs = fs;
        next_cal = cal;
        next_p112 = p112;
        next_acc = acc;
        next_n = n;
        next_idx = idx;
        next_crc = crc;
        next_stat_q = stat_q;
        next_nib_sh = nib_sh;
        next_nerr = nerr;
        next_cal_bad = cal_bad;
        next_paused = paused;
        next_done = 1'b0;
        next_fr_stat = fr_stat;
        next_fr_data = fr_data;
        next_fr_ok = fr_ok;
        twocal = AW'({cal, 1'b0});
        dif = (period > cal) ? period - cal : cal - period;
        step = p112 >= acc + twocal;
        bad = (p112 < acc) || (n > 5'(NIB_TOP));                  // RULE26
        val = 4'(n - 5'(NIB_BASE));                                 // RULE3
        case (fs)
            FS_SYNC: begin
                if (fall && en && period >= PW'(CAL_MIN) && period <= PW'(CAL_MAX)) begin
                    next_cal = period;
                    next_cal_bad = 1'b0;
                    next_fs = FS_WAIT;
                end
                next_idx = '0;
                next_nerr = 1'b0;
                next_crc = CRC4_SEED;
                next_nib_sh = '0;
                next_paused = 1'b0;
            end
            FS_WAIT: begin
                if (fall) begin
                    // rounded ticks: cal*(2n-1) <= period*2*56 < cal*(2n+1)
                    next_p112 = AW'(period) * AW'(2 * CAL_TICKS);       // RULE26
                    next_acc = AW'(cal) * AW'(2 * NIB_BASE - 1);
                    next_n = 5'(NIB_BASE);
                    next_fs = FS_DIV;
                end
            end
            FS_DIV: begin
                if (p112 >= acc && step && n <= 5'(NIB_TOP)) begin
                    next_acc = acc + twocal;
                    next_n = n + 5'h1;
                end else begin
                    next_nerr = nerr | bad;
                    next_idx = idx + 3'h1;
                    next_fs = FS_WAIT;
                    if (idx == 3'h0) begin
                        next_stat_q = val;                          // RULE6
                    end else if (idx <= nn) begin
                        next_nib_sh = {nib_sh[19:0], val};
                        next_crc = snt_crc4_nib(crc, val);
                    end
                    if (idx == nn + 3'h1) begin
                        next_done = 1'b1;
                        next_fr_stat = stat_q;
                        next_fr_data = nib_sh;
                        next_fr_ok = !(nerr | bad) && !cal_bad &&
                                     (snt_crc4_nib(crc, 4'h0) == val);
                        next_paused = 1'b0;
                        next_fs = FS_POST;
                    end
                end
            end
            FS_POST: begin
                if (fall) begin
                    if (dif <= (cal >> CAL_TOL_SHIFT)) begin
                        next_cal = period;
                        next_cal_bad = dif > (cal >> CAL_VAR_SHIFT);
                        next_idx = '0;
                        next_nerr = 1'b0;
                        next_crc = CRC4_SEED;
                        next_nib_sh = '0;
                        next_fs = FS_WAIT;
                    end else if (paused) begin
                        next_fs = FS_SYNC;
                    end else begin
                        next_paused = 1'b1;
                    end
                end
            end
            default: next_fs = FS_SYNC;
        endcase
        if (!en) begin
            next_fs = FS_SYNC;
        end
        fs_sync = (fs != FS_SYNC);
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fs <= FS_SYNC;
            cal <= '0;
            p112 <= '0;
            acc <= '0;
            n <= '0;
            idx <= '0;
            crc <= CRC4_SEED;
            stat_q <= '0;
            nib_sh <= '0;
            nerr <= 1'b0;
            cal_bad <= 1'b0;
            paused <= 1'b0;
            done <= 1'b0;
            fr_stat <= '0;
            fr_data <= '0;
            fr_ok <= 1'b0;
        end else if (ce) begin
            fs <= next_fs;
            cal <= next_cal;
            p112 <= next_p112;
            acc <= next_acc;
            n <= next_n;
            idx <= next_idx;
            crc <= next_crc;
            stat_q <= next_stat_q;
            nib_sh <= next_nib_sh;
            nerr <= next_nerr;
            cal_bad <= next_cal_bad;
            paused <= next_paused;
            done <= next_done;
            fr_stat <= next_fr_stat;
            fr_data <= next_fr_data;
            fr_ok <= next_fr_ok;
        end
    end

    // ---------------- serial channel group ----------------
    logic [4:0] scnt, next_scnt;
    logic [15:0] ssh, next_ssh;
    logic [11:0] next_short_out;
    logic [17:0] b2h, next_b2h, okh, next_okh;
    logic [18:0] b3h, next_b3h;
    logic [24:0] next_enh_out;
    logic [23:0] m;
    logic b2, b3, emark, short_hit, enh_hit;

    always_comb begin
        next_scnt = scnt;
        next_ssh = ssh;
        next_short_out = short_out;
        next_b2h = b2h;
        next_b3h = b3h;
        next_okh = okh;
        next_enh_out = enh_out;
        short_hit = 1'b0;
        enh_hit = 1'b0;
        flag_set = '0;
        b2 = fr_stat[SC_SER_BIT];                                    // RULE5
        b3 = fr_stat[SC_MARK_BIT];
        m = '0;
        emark = 1'b0;
        if (done) begin
            flag_set[ST_FRAME_BIT] = 1'b1;
            flag_set[ST_ERR_BIT] = !fr_ok;
            // short format
            next_ssh = {ssh[14:0], b2};                              // RULE8
            if (!fr_ok) begin
                next_scnt = '0;                                      // RULE10
            end else if (b3) begin
                next_scnt = 5'h1;                                    // RULE9
            end else if (scnt != 5'h0) begin
                next_scnt = scnt + 5'h1;
                if (scnt == 5'(SHORT_LEN - 1)) begin
                    next_scnt = '0;
                    // RULE11
                    if (snt_crc4_nib(snt_crc4_nib(snt_crc4_nib(snt_crc4_nib(CRC4_SEED,
                        next_ssh[15:12]), next_ssh[11:8]), next_ssh[7:4]), 4'h0)
                        == next_ssh[3:0]) begin
                        next_short_out = next_ssh[15:4];
                        short_hit = 1'b1;
                    end else begin
                        flag_set[ST_ERR_BIT] = 1'b1;
                    end
                end
            end
            // enhanced format; message k of 18 sits at index 18-k
            next_b2h = {b2h[16:0], b2};                              // RULE13
            next_b3h = {b3h[17:0], b3};
            next_okh = {okh[16:0], fr_ok};
            // RULE15 RULE24
            emark = !next_b3h[18] && (&next_b3h[17:12]) && !next_b3h[11] &&
                    !next_b3h[5] && !next_b3h[0];
            for (int i = 11; i >= 0; i--) begin
                m[2 * i + 1] = next_b2h[i];                          // RULE21 RULE22
                m[2 * i] = next_b3h[i];
            end
            if (emark && (&next_okh)) begin                          // RULE14
                if (snt_crc6(m) == next_b2h[17:12]) begin            // RULE23
                    enh_hit = 1'b1;
                    if (next_b3h[10]) begin                          // RULE18 RULE19
                        next_enh_out = {1'b1, 4'h0, next_b3h[9:6], next_b3h[4:1],
                                        next_b2h[11:0]};
                    end else begin
                        next_enh_out = {1'b0, next_b3h[9:6], next_b3h[4:1], 4'h0,
                                        next_b2h[11:0]};
                    end
                end else begin
                    flag_set[ST_ERR_BIT] = 1'b1;
                end
            end
        end
        flag_set[ST_SHORT_BIT] = short_hit;                          // RULE7
        flag_set[ST_ENH_BIT] = enh_hit;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            scnt <= '0;
            ssh <= '0;
            short_out <= '0;
            b2h <= '0;
            b3h <= '0;
            okh <= '0;
            enh_out <= '0;
        end else if (ce) begin
            scnt <= next_scnt;
            ssh <= next_ssh;
            short_out <= next_short_out;
            b2h <= next_b2h;
            b3h <= next_b3h;
            okh <= next_okh;
            enh_out <= next_enh_out;
        end
    end
endmodule
`default_nettype wire

// File: common/snt_pkg.sv
// constants, types and checksum helpers for the nibble pulse receiver
// Operation
// RULE1 - every nibble pulse lasts at least 12 ticks; value zero gives 12 ticks
// RULE2 - each pulse is low for more than 4 ticks, high for the rest
// RULE3 - each value unit adds one tick, values 0 to 15; receiver decodes likewise
// RULE4 - value fifteen gives the longest pulse, 27 ticks
// RULE5 - status bits 0 and 1 are application use, no serial meaning
// RULE6 - status nibble is excluded from the frame checksum on both ends
// RULE7 - receiver decodes both short and enhanced serial formats
// RULE8 - short format carries one serial bit in status bit 2, 16 messages
// RULE9 - short format bit 3 is one in first message, zero in next fifteen
// RULE10 - short serial value accepted only if all 16 messages are error free
// RULE11 - short message is 4-bit id, 8-bit data, 4-bit checksum over both
// RULE12 - short serial bits go out most significant bit first
// RULE13 - enhanced format uses status bits 2 and 3 over 18 messages
// RULE14 - enhanced serial value accepted only if all 18 messages are error free
// RULE15 - bit 3 pattern 01111110 marks enhanced start; first one begins frame
// RULE16 - bit 3 of enhanced message 13 is always zero
// RULE17 - after reset transmitter sends zero bit 3 values before the start pattern
// RULE18 - enhanced frame carries 20 payload bits; config bit in message 8 bit 3
// RULE19 - config zero: 12 data bits, 8-bit id; config one: 16 data, 4-bit id
// RULE20 - every enhanced field goes out most significant bit first
// RULE21 - enhanced checksum covers bit 2 then bit 3 of messages 7 to 18
// RULE22 - first checksum input bit is the most significant data bit
// RULE23 - enhanced checksum: x^6+x^4+x^3+1, seed 010101, six zeros appended
// RULE24 - enhanced frame is erroneous if bit 3 of message 7, 13 or 18 is set
// RULE25 - enhanced checksum sits in bit 2 of messages 1 to 6, msb first
// RULE26 - nibble value is rounded period over tick minus twelve; outside 0..15 errs
package snt_pkg;
    // timing
    localparam int CLK_NS = 10;
    localparam int TICK_MIN_NS = 3000;
    localparam int TICK_MAX_NS = 90000;
    localparam int TOL_PCT = 20;
    localparam int CAL_TICKS = 56;
    localparam int NIB_BASE = 12;
    localparam int NIB_SPAN = 15;
    localparam int NIB_TOP = NIB_BASE + NIB_SPAN;
    localparam int CAL_MIN_CYC = (TICK_MIN_NS * CAL_TICKS * (100 - TOL_PCT)) / (100 * CLK_NS);
    localparam int CAL_MAX_CYC = (TICK_MAX_NS * CAL_TICKS * (100 + TOL_PCT)) / (100 * CLK_NS);
    localparam int CAL_TOL_SHIFT = 2;
    localparam int CAL_VAR_SHIFT = 6;
    localparam int MAX_NIB = 6;
    // serial channel layout
    localparam int SC_SER_BIT = 2;
    localparam int SC_MARK_BIT = 3;
    localparam int SHORT_LEN = 16;
    localparam int ENH_LEN = 18;
    // checksums
    localparam logic [3:0] CRC4_SEED = 4'h5;
    localparam logic [3:0] CRC4_POLY = 4'hd;
    localparam logic [5:0] CRC6_SEED = 6'h15;
    localparam logic [5:0] CRC6_POLY = 6'h19;
    // register map
    localparam logic [7:0] REG_CTRL = 8'h00;
    localparam logic [7:0] REG_STAT = 8'h04;
    localparam logic [7:0] REG_FRAME = 8'h08;
    localparam logic [7:0] REG_DATA = 8'h0c;
    localparam logic [7:0] REG_SHORT = 8'h10;
    localparam logic [7:0] REG_ENH = 8'h14;
    localparam logic [7:0] REG_CAL = 8'h18;
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_NN_LSB = 4;
    localparam logic [6:0] CTRL_RESET = 7'h61;
    localparam int ST_FRAME_BIT = 0;
    localparam int ST_SHORT_BIT = 1;
    localparam int ST_ENH_BIT = 2;
    localparam int ST_ERR_BIT = 3;
    localparam int ST_SYNC_BIT = 8;
    localparam int FRAME_OK_BIT = 31;
    localparam int ENH_ID_LSB = 16;
    localparam int ENH_CFG_BIT = 24;

    typedef enum logic [1:0] {
        FS_SYNC = 2'b00,
        FS_WAIT = 2'b01,
        FS_DIV = 2'b10,
        FS_POST = 2'b11
    } snt_fs_e;

    // one nibble through the augmented 4-bit checksum, msb first
    function automatic logic [3:0] snt_crc4_nib(input logic [3:0] r, input logic [3:0] d);
        logic [3:0] c;
        logic fb;
        c = r;
        for (int i = 3; i >= 0; i--) begin
            fb = c[3];
            c = {c[2:0], d[i]};
            if (fb) begin
                c = c ^ CRC4_POLY;
            end
        end
        return c;
    endfunction

    // enhanced checksum over 24 bits plus six zero bits, m0 at bit 23
    function automatic logic [5:0] snt_crc6(input logic [23:0] m);
        logic [29:0] s;
        logic [5:0] c;
        logic fb;
        s = {m, 6'h00};
        c = CRC6_SEED;
        for (int i = 29; i >= 0; i--) begin
            fb = c[5];
            c = {c[4:0], s[i]};
            if (fb) begin
                c = c ^ CRC6_POLY;
            end
        end
        return c;
    endfunction
endpackage

// File: hw/snt_edge.sv
// line synchroniser, glitch filter and falling-edge interval meter
`timescale 1ns/1ps
`default_nettype none
module snt_edge #(
    parameter int PW = 20
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // line from the sensor
    input wire logic line_in,
    // measured interval
    output logic fall,
    output logic [PW-1:0] period
);
    logic s1, s2, s3, lvl, next_lvl, next_fall;
    logic [PW-1:0] cnt, next_cnt, next_period;

    always_comb begin
        next_lvl = (s2 == s3) ? s3 : lvl;
        next_fall = lvl & ~next_lvl;
        next_cnt = next_fall ? PW'(1) : ((&cnt) ? cnt : cnt + PW'(1));
        next_period = next_fall ? cnt : period;
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1 <= 1'b1;
            s2 <= 1'b1;
            s3 <= 1'b1;
            lvl <= 1'b1;
            fall <= 1'b0;
            cnt <= '0;
            period <= '0;
        end else if (ce) begin
            s1 <= line_in;
            s2 <= s1;
            s3 <= s2;
            lvl <= next_lvl;
            fall <= next_fall;
            cnt <= next_cnt;
            period <= next_period;
        end
    end
endmodule
`default_nettype wire

// File: sim/snt_rx_properties.sv
// apb contract checks on the nibble pulse receiver ports
`timescale 1ns/1ps
`default_nettype none
module snt_rx_props
    import snt_pkg::*;
(
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // sensor line
    input wire logic sent_in
);
    logic unmapped;
    assign unmapped = !(paddr inside {REG_CTRL, REG_STAT, REG_FRAME, REG_DATA, REG_SHORT, REG_ENH,
        REG_CAL});
    default clocking @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    ready_ce_a: assert property (pready == ce) else $error("pready differs from ce");
    err_access_a: assert property (pslverr |-> psel && penable) else $error("stray pslverr");
    err_unmapped_a: assert property (psel && penable && pready && unmapped |-> pslverr)
        else $error("unmapped access not refused");
    ok_mapped_a: assert property (psel && penable && !unmapped |-> !pslverr)
        else $error("mapped access refused");
    unmapped_zero_a: assert property (psel && penable && !pwrite && unmapped |-> prdata == 32'h0)
        else $error("unmapped read not zero");
    rdata_hold_a: assert property (psel && penable && pready |=> $stable(prdata))
        else $error("read data moved after access");
    release_zero_a: assert property ($rose(presetn) |-> prdata == 32'h0 && !pslverr)
        else $error("outputs not clear after reset");
    reset_quiet_a: assert property (disable iff (1'b0) !presetn |-> prdata == 32'h0 && !pslverr)
        else $error("outputs active in reset");
endmodule
bind snt_rx snt_rx_props snt_rx_props_inst (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .sent_in(sent_in)
);
`default_nettype wire

// File: sim/snt_sensor_model.sv
// behavioural sensor sending nibble frames with short or enhanced serial data
`timescale 1ns/1ps
`default_nettype none
module snt_sensor_model #(
    parameter int TICK = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // frame contents
    input wire logic enh,
    input wire logic cfg,
    input wire logic [7:0] sid,
    input wire logic [15:0] sdat,
    input wire logic [3:0] dnib,
    input wire logic [1:0] app,
    input wire logic bad,
    // line and frame count
    output logic sent_in,
    output logic [15:0] frames
);
    logic [0:17] b2;
    logic [0:17] b3;
    logic [15:0] dd;
    logic [23:0] m;
    logic [3:0] st;
    logic lead;
    logic was;
    int pos;
    int len;

    function automatic logic [3:0] c4(input logic [3:0] r, input logic [3:0] d);
        for (int i = 3; i >= 0; i--) begin
            r = {r[2:0], d[i]} ^ (r[3] ? 4'hd : 4'h0);
        end
        return r;
    endfunction

    function automatic logic [5:0] c6(input logic [23:0] mm);
        logic [29:0] s;
        logic [5:0] c;
        s = {mm, 6'h00};
        c = 6'h15;
        for (int i = 29; i >= 0; i--) begin
            c = {c[4:0], s[i]} ^ (c[5] ? 6'h19 : 6'h00);
        end
        return c;
    endfunction

    task automatic pulse(input int ticks);
        sent_in <= 1'b0;
        repeat (5 * TICK) @(posedge pclk);
        sent_in <= 1'b1;
        repeat ((ticks - 5) * TICK) @(posedge pclk);
    endtask

    // latch one serial message at its first frame
    task automatic build;
        b2 = '0;
        b3 = '0;
        lead = enh && !was;
        was = enh;
        if (!enh) begin
            len = 16;
            b2[0:15] = {sid[3:0], sdat[7:0],
                c4(c4(c4(c4(4'h5, sid[3:0]), sdat[7:4]), sdat[3:0]), 4'h0)};
            b3[0] = 1'b1;
        end else begin
            len = 18;
            dd = cfg ? sdat : {4'h0, sdat[11:0]};
            b2[6:17] = dd[11:0];
            b3 = {6'h3f, 1'b0, cfg, cfg ? sid[3:0] : sid[7:4], 1'b0,
                cfg ? dd[15:12] : sid[3:0], 1'b0};
            for (int k = 6; k < 18; k++) begin
                m[35 - 2 * k -: 2] = {b2[k], b3[k]};
            end
            b2[0:5] = c6(m);
        end
    endtask

    initial begin
        sent_in = 1'b1;
        frames = '0;
        pos = 0;
        was = 1'b0;
        @(posedge pclk iff presetn === 1'b1);
        forever begin
            if (pos == 0) begin
                build();
            end
            st = {lead ? 2'b00 : {b3[pos], b2[pos]}, app};
            frames <= frames + 16'h1;
            pulse(56);
            pulse(12 + int'(st));
            pulse(12 + int'(dnib));
            pulse(12 + int'(c4(c4(4'h5, dnib), 4'h0) ^ {3'h0, bad}));
            pos = lead ? pos : (pos + 1) % len;
            lead = 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: sim/tb_top.sv
// self-checking bench for the nibble pulse receiver
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import snt_pkg::*;
    logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr, sent_in;
    logic [7:0] paddr;
    logic [31:0] pwdata, prdata, r;
    logic enh, cfg, bad, e;
    logic [7:0] sid;
    logic [15:0] sdat, frames, f;
    logic [3:0] dnib;
    logic [1:0] app;
    int seed, n, miscompares, tests_run;

    snt_rx #(.PW(20), .CAL_MIN(100), .CAL_MAX(1000)) snt_rx_inst (.pclk(pclk),
        .presetn(presetn), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .sent_in(sent_in));
    snt_sensor_model #(.TICK(4)) snt_sensor_model_inst (.pclk(pclk), .presetn(presetn),
        .enh(enh), .cfg(cfg), .sid(sid), .sdat(sdat), .dnib(dnib), .app(app), .bad(bad),
        .sent_in(sent_in), .frames(frames));

    initial begin
        pclk = 1'b0;
        forever #5 pclk = ~pclk;
    end

    task automatic finish_test;
        $display("comparisons %0d mismatches %0d", tests_run, miscompares);
        if (miscompares == 0 && tests_run > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    task automatic check(input logic [31:0] got, input logic [31:0] exp, input string what);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("[FAIL] %0t %s: got %h expected %h", $time, what, got, exp);
        end
    endtask

    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 40);
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (pready !== 1'b1) begin
            miscompares++;
            finish_test();
        end
        @(posedge pclk);
    endtask

    task automatic wait_bit(input int b);
        // poll afresh: r may still hold status read before the clear
        r = '0;
        for (n = 0; n < 12000 && r[b] !== 1'b1; n++) begin
            apb(1'b0, REG_STAT, 32'h0);
        end
        if (r[b] !== 1'b1) begin
            miscompares++;
            finish_test();
        end
    endtask

    task automatic wait_frames(input logic [15:0] t);
        for (n = 0; n < 10000 && frames !== t; n++) begin
            @(posedge pclk);
        end
        if (frames !== t) begin
            miscompares++;
            finish_test();
        end
    endtask

    function automatic logic [31:0] enh_exp(input logic c, input logic [7:0] id,
        input logic [15:0] d);
        return c ? {7'h0, 1'b1, 4'h0, id[3:0], d} : {7'h0, 1'b0, id, 4'h0, d[11:0]};
    endfunction

    initial begin
        seed = 66997;
        {miscompares, tests_run} = '0;
        {presetn, psel, penable, pwrite, enh, cfg, bad, paddr, pwdata, r} = '0;
        ce = 1'b1;
        {sid, sdat, dnib, app} = 30'($random(seed));
        repeat (8) @(posedge pclk);
        presetn <= 1'b1;
        @(posedge pclk);
        apb(1'b0, REG_CTRL, 32'h0);
        check(r, {25'h0, CTRL_RESET}, "ctrl reset");
        apb(1'b0, 8'h40, 32'h0);
        check({31'h0, e}, 32'h1, "unmapped refused");
        check(r, 32'h0, "unmapped read");
        apb(1'b1, REG_CTRL, 32'h11);
        apb(1'b0, REG_CTRL, 32'h0);
        check(r, 32'h11, "ctrl write");
        wait_bit(ST_SHORT_BIT);
        f = frames;
        apb(1'b0, REG_SHORT, 32'h0);
        check(r, {20'h0, sid[3:0], sdat[7:0]}, "short message");
        apb(1'b0, REG_FRAME, 32'h0);
        check(r & 32'h8000_0003, {1'b1, 29'h0, app}, "frame ok, app bits");
        apb(1'b0, REG_DATA, 32'h0);
        check(r & 32'hf, {28'h0, dnib}, "data nibble");
        apb(1'b0, REG_CAL, 32'h0);
        check(r, 32'(CAL_TICKS * 4), "calibration period");
        apb(1'b1, REG_STAT, 32'hf);
        wait_frames(f + 16'h1);
        bad <= 1'b1;
        wait_frames(f + 16'h2);
        bad <= 1'b0;
        wait_frames(f + 16'h10);
        repeat (300) @(posedge pclk);
        apb(1'b0, REG_STAT, 32'h0);
        check(r & 32'h10a, 32'h108, "short message with bad frame");
        for (int c = 0; c < 2; c++) begin
            enh <= 1'b1;
            cfg <= c[0];
            {sid, sdat} <= 24'($random(seed));
            repeat (2) begin
                apb(1'b1, REG_STAT, 32'hf);
                wait_bit(ST_ENH_BIT);
            end
            apb(1'b0, REG_ENH, 32'h0);
            check(r, enh_exp(c[0], sid, sdat), "enhanced message");
        end
        finish_test();
    end
endmodule
`default_nettype wire
